// ### verilog/dsa_pkg.sv
// Package for the DSP accumulator datapath: map, fields, codes, carriers
package dsa_pkg;

    // Register indices on the plain register port
    localparam logic [3:0] REG_CORE_CTRL = 4'h0;
    localparam logic [3:0] REG_TRAP_CTRL = 4'h1;
    localparam logic [3:0] REG_STATUS = 4'h2;
    localparam logic [3:0] REG_WB_PTR = 4'h3;
    localparam logic [3:0] REG_ACC_A_LO = 4'h4;
    localparam logic [3:0] REG_ACC_A_HI = 4'h5;
    localparam logic [3:0] REG_ACC_A_UP = 4'h6;
    localparam logic [3:0] REG_ACC_B_LO = 4'h7;
    localparam logic [3:0] REG_ACC_B_HI = 4'h8;
    localparam logic [3:0] REG_ACC_B_UP = 4'h9;

    // Field positions in core_control_reg
    localparam int CC_ROUND_SEL = 1;
    localparam int CC_WIDTH_SEL = 4;
    localparam int CC_STORE_CLAMP = 5;
    localparam int CC_CLAMP_B = 6;
    localparam int CC_CLAMP_A = 7;

    // Field positions in trap_control_reg
    localparam int TC_SIGN_LOSS = 0;
    localparam int TC_GUARD_A = 1;
    localparam int TC_GUARD_B = 2;

    // Field positions in the status word
    localparam int ST_GUARD_A = 0;
    localparam int ST_GUARD_B = 1;
    localparam int ST_LIMIT_A = 2;
    localparam int ST_LIMIT_B = 3;
    localparam int ST_ANY_GUARD = 4;
    localparam int ST_ANY_LIMIT = 5;

    // Reset values
    localparam logic [15:0] CORE_CTRL_RST = 16'h0000;
    localparam logic [15:0] TRAP_CTRL_RST = 16'h0000;
    localparam logic [15:0] WB_PTR_RST = 16'h0000;

    // Clamp limits, round half point and write-back step
    localparam logic [39:0] LIM40_POS = 40'h7fffffffff;
    localparam logic [39:0] LIM40_NEG = 40'h8000000000;
    localparam logic [39:0] LIM32_POS = 40'h007fffffff;
    localparam logic [39:0] LIM32_NEG = 40'h0080000000;
    localparam logic [15:0] STORE_POS = 16'h7fff;
    localparam logic [15:0] STORE_NEG = 16'h8000;
    localparam logic [15:0] ROUND_HALF = 16'h8000;
    localparam logic [15:0] WB_STEP = 16'h0002;

    // Operation codes from the sequencer
    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_ADD = 4'h1,
        OP_SUB = 4'h2,
        OP_MAC = 4'h3,
        OP_MSC = 4'h4,
        OP_MPY = 4'h5,
        OP_MPYN = 4'h6,
        OP_SQD = 4'h7,
        OP_SQDA = 4'h8,
        OP_STORE = 4'h9,
        OP_STORE_RND = 4'ha,
        OP_SHIFT_ACC = 4'hb,
        OP_SHIFT_GP = 4'hc
    } dsa_op_t;

    // One operation request
    typedef struct packed {
        dsa_op_t code;
        logic acc_sel;
        logic zero_src;
        logic wb_en;
        logic wb_indirect;
        logic [39:0] operand;
        logic signed [5:0] shift_amt;
        logic shift_arith;
        logic shift_from_x;
        logic [15:0] xdata;
        logic [15:0] xaddr;
    } dsa_req_t;

    // One data-space write
    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic [15:0] data;
    } dsa_xwr_t;

endpackage

// ### verilog/dsa_datapath.sv
// DSP accumulator datapath: adder, clamping, flags, round, store, shifter
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps

module dsa_datapath (
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic [3:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [15:0] REG_RDATA,
    input wire logic OP_VALID,
    input wire dsa_pkg::dsa_req_t OP_REQ,
    output dsa_pkg::dsa_xwr_t XBUS_WR,
    output logic [39:0] SHIFT_RESULT,
    output logic [15:0] GP_RESULT,
    output logic GP_VALID,
    output logic ARITH_TRAP,
    output logic [5:0] STATUS_FLAGS
);

    ////////////////////////////////////////////////////////////////////////
    // State
    logic [15:0] core_control_reg;
    logic [15:0] trap_control_reg;
    logic [15:0] writeback_pointer_reg;
    logic [39:0] acc_reg [0:1];
    logic [1:0] guard_ovf_reg;
    logic [1:0] limit_hit_reg;
    logic any_guard_reg;
    logic any_limit_reg;

    // Decoded controls
    logic round_mode_sel;
    logic clamp_width_sel;
    logic store_clamp_en;
    logic [1:0] clamp_en;
    logic sign_loss_trap_en;
    logic [1:0] guard_trap_en;

    // Op decode
    dsa_pkg::dsa_op_t code;
    logic sel;
    logic use_adder;
    logic do_sub;
    logic force_zero;
    logic wb_go;
    logic store_go;

    // Adder and clamping
    logic [39:0] acc_src;
    logic [40:0] add_a;
    logic [40:0] add_b;
    logic [40:0] sum;
    logic ovf39;
    logic ovf31;
    logic guard_hit;
    logic en_sel;
    logic mode32;
    logic limit_set;
    logic [39:0] acc_result;
    logic [1:0] guard_next;
    logic [1:0] limit_next;

    // Round and store
    logic [39:0] st_src;
    logic st_round;
    logic st_inc;
    logic [23:0] st_val;
    logic [15:0] st_word;

    // Shifter
    logic [39:0] sh_src;
    logic [4:0] sh_mag;
    logic sh_right;
    logic [39:0] sh_out;

    ////////////////////////////////////////////////////////////////////////
    // Control fields
    assign round_mode_sel = core_control_reg[dsa_pkg::CC_ROUND_SEL];
    assign clamp_width_sel = core_control_reg[dsa_pkg::CC_WIDTH_SEL];
    assign store_clamp_en = core_control_reg[dsa_pkg::CC_STORE_CLAMP];
    assign clamp_en[0] = core_control_reg[dsa_pkg::CC_CLAMP_A];
    assign clamp_en[1] = core_control_reg[dsa_pkg::CC_CLAMP_B];
    assign sign_loss_trap_en = trap_control_reg[dsa_pkg::TC_SIGN_LOSS];
    assign guard_trap_en[0] = trap_control_reg[dsa_pkg::TC_GUARD_A];
    assign guard_trap_en[1] = trap_control_reg[dsa_pkg::TC_GUARD_B];

    // Operation class decode
    assign code = OP_VALID ? OP_REQ.code : dsa_pkg::OP_NONE;
    assign sel = OP_REQ.acc_sel;
    assign use_adder = (code == dsa_pkg::OP_ADD) || (code == dsa_pkg::OP_SUB)
        || (code == dsa_pkg::OP_MAC) || (code == dsa_pkg::OP_MSC)
        || (code == dsa_pkg::OP_MPY) || (code == dsa_pkg::OP_MPYN)
        || (code == dsa_pkg::OP_SQD) || (code == dsa_pkg::OP_SQDA);
    assign do_sub = (code == dsa_pkg::OP_SUB) || (code == dsa_pkg::OP_MSC)
        || (code == dsa_pkg::OP_MPYN);
    assign force_zero = (code == dsa_pkg::OP_MPY) || (code == dsa_pkg::OP_MPYN)
        || (code == dsa_pkg::OP_SQD)
        || (((code == dsa_pkg::OP_ADD) || (code == dsa_pkg::OP_SUB)) && OP_REQ.zero_src);
    // Only plain accumulate ops may write back
    assign wb_go = OP_REQ.wb_en
        && ((code == dsa_pkg::OP_MAC) || (code == dsa_pkg::OP_MSC));
    assign store_go = (code == dsa_pkg::OP_STORE) || (code == dsa_pkg::OP_STORE_RND);

    ////////////////////////////////////////////////////////////////////////
    // Adder: 41-bit sum keeps the true sign beyond bit 39
    assign acc_src = force_zero ? 40'h0000000000 : acc_reg[sel];
    assign add_a = {acc_src[39], acc_src};
    assign add_b = {OP_REQ.operand[39], OP_REQ.operand};
    // Subtract: complement with carry in high (borrow in low, inactive)
    assign sum = add_a + (do_sub ? ~add_b : add_b) + {40'h0000000000, do_sub};

    // Overflow detection
    assign ovf39 = sum[40] ^ sum[39];
    assign ovf31 = ~((&sum[40:31]) | ~(|sum[40:31]));
    assign en_sel = clamp_en[sel];
    assign mode32 = en_sel && !clamp_width_sel;
    // Guard bits unused while 32-bit clamping is active
    assign guard_hit = ~((&sum[39:32]) | ~(|sum[39:32])) && !mode32;

    // Clamp selection by mode
    always_comb begin
        acc_result = sum[39:0];
        limit_set = 1'b0;
        if (en_sel && clamp_width_sel && ovf39) begin
            acc_result = sum[40] ? dsa_pkg::LIM40_NEG : dsa_pkg::LIM40_POS;
            limit_set = 1'b1;
        end else if (mode32 && ovf31) begin
            acc_result = sum[40] ? dsa_pkg::LIM32_NEG : dsa_pkg::LIM32_POS;
            limit_set = 1'b1;
        end else if (!en_sel && ovf39) begin
            limit_set = 1'b1;
        end
    end

    // Flag next values: guard follows op, limit sticky, set beats clear
    always_comb begin
        guard_next = guard_ovf_reg;
        limit_next = limit_hit_reg;
        if (REG_WR && REG_ADDR == dsa_pkg::REG_STATUS) begin
            limit_next[0] = limit_hit_reg[0] & REG_WDATA[dsa_pkg::ST_LIMIT_A];
            limit_next[1] = limit_hit_reg[1] & REG_WDATA[dsa_pkg::ST_LIMIT_B];
        end
        if (use_adder) begin
            guard_next[sel] = guard_hit;
            limit_next[sel] = limit_next[sel] | limit_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Round logic and store clamping
    assign st_src = wb_go ? acc_reg[~sel] : acc_reg[sel];
    assign st_round = wb_go || (code == dsa_pkg::OP_STORE_RND);
    // Convergent keeps exact half unchanged when bit 16 is zero
    assign st_inc = st_round && st_src[15]
        && (!round_mode_sel || (st_src[15:0] != dsa_pkg::ROUND_HALF)
        || st_src[16]);
    assign st_val = st_src[39:16] + {23'h000000, st_inc};

    // Sign from bit 39 decides which limit is tested
    always_comb begin
        st_word = st_val[15:0];
        if (store_clamp_en) begin
            if (!st_src[39] && (st_val[23:15] != 9'h000)) begin
                st_word = dsa_pkg::STORE_POS;
            end else if (st_src[39] && (st_val[23:15] != 9'h1ff)) begin
                st_word = dsa_pkg::STORE_NEG;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Barrel shifter
    assign sh_right = !OP_REQ.shift_amt[5];
    assign sh_mag = sh_right ? OP_REQ.shift_amt[4:0] : 5'(-OP_REQ.shift_amt);

    // Source placement depends on direction for X data
    always_comb begin
        if (!OP_REQ.shift_from_x) begin
            sh_src = acc_reg[sel];
        end else if (sh_right) begin
            sh_src = {{8{OP_REQ.shift_arith & OP_REQ.xdata[15]}},
                OP_REQ.xdata, 16'h0000};
        end else begin
            sh_src = {24'h000000, OP_REQ.xdata};
        end
    end

    // Right arithmetic or logical, left logical; zero is pass-through
    always_comb begin
        if (!sh_right) begin
            sh_out = sh_src << sh_mag;
        end else if (OP_REQ.shift_arith) begin
            sh_out = 40'($signed(sh_src) >>> sh_mag);
        end else begin
            sh_out = sh_src >> sh_mag;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software control registers
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            core_control_reg <= dsa_pkg::CORE_CTRL_RST;
            trap_control_reg <= dsa_pkg::TRAP_CTRL_RST;
        end else if (REG_WR) begin
            if (REG_ADDR == dsa_pkg::REG_CORE_CTRL) begin
                core_control_reg <= REG_WDATA;
            end
            if (REG_ADDR == dsa_pkg::REG_TRAP_CTRL) begin
                trap_control_reg <= REG_WDATA;
            end
        end
    end

    // Write-back pointer: the datapath update wins over software
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            writeback_pointer_reg <= dsa_pkg::WB_PTR_RST;
        end else if (wb_go && !OP_REQ.wb_indirect) begin
            writeback_pointer_reg <= st_word;
        end else if (wb_go) begin
            writeback_pointer_reg <= writeback_pointer_reg + dsa_pkg::WB_STEP;
        end else if (REG_WR && REG_ADDR == dsa_pkg::REG_WB_PTR) begin
            writeback_pointer_reg <= REG_WDATA;
        end
    end

    // Accumulators
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            acc_reg[0] <= 40'h0000000000;
            acc_reg[1] <= 40'h0000000000;
        end else if (use_adder) begin
            acc_reg[sel] <= acc_result;
        end else if (code == dsa_pkg::OP_SHIFT_ACC) begin
            acc_reg[sel] <= sh_out;
        end
    end

    // Flags and their combined copies
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            guard_ovf_reg <= 2'h0;
            limit_hit_reg <= 2'h0;
            any_guard_reg <= 1'b0;
            any_limit_reg <= 1'b0;
        end else begin
            guard_ovf_reg <= guard_next;
            limit_hit_reg <= limit_next;
            any_guard_reg <= |guard_next;
            any_limit_reg <= |limit_next;
        end
    end

    // Arithmetic warning trap pulse
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            ARITH_TRAP <= 1'b0;
        end else begin
            ARITH_TRAP <= use_adder
                && ((guard_hit && guard_trap_en[sel])
                || (!en_sel && ovf39 && sign_loss_trap_en));
        end
    end

    // Data-space write port
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            XBUS_WR <= '0;
        end else begin
            XBUS_WR.valid <= store_go || (wb_go && OP_REQ.wb_indirect);
            XBUS_WR.addr <= wb_go ? writeback_pointer_reg : OP_REQ.xaddr;
            XBUS_WR.data <= st_word;
        end
    end

    // Shifter results
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            SHIFT_RESULT <= 40'h0000000000;
            GP_RESULT <= 16'h0000;
            GP_VALID <= 1'b0;
        end else begin
            GP_VALID <= (code == dsa_pkg::OP_SHIFT_GP);
            if (code == dsa_pkg::OP_SHIFT_ACC) begin
                SHIFT_RESULT <= sh_out;
            end
            if (code == dsa_pkg::OP_SHIFT_GP) begin
                GP_RESULT <= sh_right ? sh_out[31:16] : sh_out[15:0];
            end
        end
    end

    // Status output
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            STATUS_FLAGS <= 6'h00;
        end else begin
            STATUS_FLAGS <= {|limit_next, |guard_next, limit_next, guard_next};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read, data one cycle after the strobe
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            REG_RDATA <= 16'h0000;
        end else if (REG_RD) begin
            unique case (REG_ADDR)
                dsa_pkg::REG_CORE_CTRL: REG_RDATA <= core_control_reg;
                dsa_pkg::REG_TRAP_CTRL: REG_RDATA <= trap_control_reg;
                dsa_pkg::REG_STATUS: REG_RDATA <= {10'h000, any_limit_reg,
                    any_guard_reg, limit_hit_reg, guard_ovf_reg};
                dsa_pkg::REG_WB_PTR: REG_RDATA <= writeback_pointer_reg;
                dsa_pkg::REG_ACC_A_LO: REG_RDATA <= acc_reg[0][15:0];
                dsa_pkg::REG_ACC_A_HI: REG_RDATA <= acc_reg[0][31:16];
                dsa_pkg::REG_ACC_A_UP: REG_RDATA <= {8'h00, acc_reg[0][39:32]};
                dsa_pkg::REG_ACC_B_LO: REG_RDATA <= acc_reg[1][15:0];
                dsa_pkg::REG_ACC_B_HI: REG_RDATA <= acc_reg[1][31:16];
                dsa_pkg::REG_ACC_B_UP: REG_RDATA <= {8'h00, acc_reg[1][39:32]};
                default: REG_RDATA <= 16'h0000;
            endcase
        end else begin
            REG_RDATA <= 16'h0000;
        end
    end

endmodule

// ### dv/dsa_datapath_chk.sv
// Port checker for the accumulator datapath, bound to its top module
`timescale 1ns/1ps
module dsa_datapath_chk (
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic [3:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [15:0] REG_RDATA,
    input wire logic OP_VALID,
    input wire dsa_pkg::dsa_req_t OP_REQ,
    input wire dsa_pkg::dsa_xwr_t XBUS_WR,
    input wire logic [39:0] SHIFT_RESULT,
    input wire logic [15:0] GP_RESULT,
    input wire logic GP_VALID,
    input wire logic ARITH_TRAP,
    input wire logic [5:0] STATUS_FLAGS
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET);
    ////////////////////////////////////////////////////////////////////////////////
    // Request kinds
    sequence s_store;
        OP_VALID && (OP_REQ.code inside {dsa_pkg::OP_STORE, dsa_pkg::OP_STORE_RND});
    endsequence
    sequence s_gpx;
        OP_VALID && OP_REQ.code == dsa_pkg::OP_SHIFT_GP && OP_REQ.shift_from_x;
    endsequence
    sequence s_xwrite;
        XBUS_WR.valid && XBUS_WR.addr == $past(OP_REQ.xaddr);
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    // Relations at the ports
    AST_STORE_WRITE: assert property (s_store |=> s_xwrite)
        else $error("store gave no write at its address");
    AST_NO_WB_MPY: assert property (OP_VALID && (OP_REQ.code inside {dsa_pkg::OP_MPY,
        dsa_pkg::OP_MPYN, dsa_pkg::OP_SQD, dsa_pkg::OP_SQDA}) |=> !XBUS_WR.valid)
        else $error("multiply kind wrote data space");
    AST_GP_PULSE: assert property (s_gpx |=> GP_VALID)
        else $error("general shift gave no result pulse");
    AST_GP_CAUSE: assert property (GP_VALID |-> $past(OP_VALID)
        && $past(OP_REQ.code) == dsa_pkg::OP_SHIFT_GP)
        else $error("result pulse without general shift");
    AST_ANY_GUARD: assert property (STATUS_FLAGS[4] == (STATUS_FLAGS[0] | STATUS_FLAGS[1]))
        else $error("combined guard flag wrong");
    AST_ANY_LIMIT: assert property (STATUS_FLAGS[5] == (STATUS_FLAGS[2] | STATUS_FLAGS[3]))
        else $error("combined limit flag wrong");
    AST_LIMIT_STICKY: assert property (!$past(RESET) && $past(STATUS_FLAGS[2])
        && !$past(REG_WR && REG_ADDR == dsa_pkg::REG_STATUS) |-> STATUS_FLAGS[2])
        else $error("limit flag cleared without software write");
    AST_GP_ZERO: assert property (s_gpx ##0 OP_REQ.shift_amt == 6'sd0
        |=> GP_RESULT == $past(OP_REQ.xdata))
        else $error("zero shift changed operand");
    AST_GP_LEFT1: assert property (s_gpx ##0 OP_REQ.shift_amt == -6'sd1
        |=> GP_RESULT == {$past(OP_REQ.xdata[14:0]), 1'b0})
        else $error("left shift by one wrong");
    AST_GP_RIGHT1: assert property (s_gpx ##0 OP_REQ.shift_amt == 6'sd1 ##0 !OP_REQ.shift_arith
        |=> GP_RESULT == {1'b0, $past(OP_REQ.xdata[15:1])})
        else $error("logical right shift by one wrong");
    AST_TRAP_CAUSE: assert property (ARITH_TRAP |-> $past(OP_VALID))
        else $error("trap without an operation");
endmodule

bind dsa_datapath dsa_datapath_chk u_dsa_datapath_chk (.MCLK(MCLK), .RESET(RESET),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .OP_VALID(OP_VALID), .OP_REQ(OP_REQ), .XBUS_WR(XBUS_WR),
    .SHIFT_RESULT(SHIFT_RESULT), .GP_RESULT(GP_RESULT), .GP_VALID(GP_VALID),
    .ARITH_TRAP(ARITH_TRAP), .STATUS_FLAGS(STATUS_FLAGS));

// ### dv/dsa_xmem.sv
// Data-space word memory standing on the X write bus
`timescale 1ns/1ps
module dsa_xmem (
    input wire logic mclk,
    input wire logic reset,
    input wire dsa_pkg::dsa_xwr_t xwr,
    input wire logic [15:0] peek_addr,
    output logic [15:0] peek_data,
    output logic [15:0] wr_count
);
    logic [15:0] mem_reg [0:255];
    // Word write, taken at the edge that ends the valid cycle
    always_ff @(posedge mclk) begin
        if (xwr.valid) begin
            mem_reg[xwr.addr[8:1]] <= xwr.data;
        end
    end
    // Count of writes seen
    always_ff @(posedge mclk) begin
        if (reset) begin
            wr_count <= 16'h0000;
        end else if (xwr.valid) begin
            wr_count <= wr_count + 16'h0001;
        end
    end
    assign peek_data = mem_reg[peek_addr[8:1]];
endmodule

// ### dv/tb.sv
// Self-checking bench for the accumulator datapath
`timescale 1ns/1ps
module tb;
    logic MCLK = 1'b0;
    logic RESET = 1'b1;
    logic [3:0] REG_ADDR = 4'h0;
    logic [15:0] REG_WDATA = 16'h0000;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic [15:0] REG_RDATA;
    logic OP_VALID = 1'b0;
    dsa_pkg::dsa_req_t OP_REQ = '0;
    dsa_pkg::dsa_req_t q;
    dsa_pkg::dsa_xwr_t XBUS_WR;
    logic [39:0] SHIFT_RESULT;
    logic [15:0] GP_RESULT, peek_data, wr_count, rd, cnt;
    logic GP_VALID, ARITH_TRAP;
    logic [5:0] STATUS_FLAGS;
    logic [15:0] peek_addr = 16'h0000;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;
    logic signed [5:0] amts [8] = '{6'sd4, 6'sd4, -6'sd4, 6'sd0, 6'sd16, -6'sd16, 6'sd1,
        -6'sd1};
    logic ariths [8] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    logic [15:0] gp_exp [8] = '{16'hf842, 16'h0842, 16'h4210, 16'h8421, 16'hffff, 16'h0000,
        16'h4210, 16'h0842};

    dsa_datapath u_dsa_datapath (.MCLK(MCLK), .RESET(RESET), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
        .OP_VALID(OP_VALID), .OP_REQ(OP_REQ), .XBUS_WR(XBUS_WR), .SHIFT_RESULT(SHIFT_RESULT),
        .GP_RESULT(GP_RESULT), .GP_VALID(GP_VALID), .ARITH_TRAP(ARITH_TRAP),
        .STATUS_FLAGS(STATUS_FLAGS));
    dsa_xmem u_dsa_xmem (.mclk(MCLK), .reset(RESET), .xwr(XBUS_WR), .peek_addr(peek_addr),
        .peek_data(peek_data), .wr_count(wr_count));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial forever #2 MCLK = ~MCLK;
    always @(posedge MCLK) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Compare, bus and operation tasks
    task automatic chk(input string name, input logic [39:0] seen, input logic [39:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge MCLK);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge MCLK);
        REG_WR <= 1'b0;
    endtask
    task automatic rd_chk(input string name, input logic [3:0] a, input logic [15:0] e);
        @(posedge MCLK);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge MCLK);
        REG_RD <= 1'b0;
        #1 rd = REG_RDATA;
        chk(name, 40'(rd), 40'(e));
    endtask
    task automatic send(input dsa_pkg::dsa_req_t r);
        @(posedge MCLK);
        OP_VALID <= 1'b1;
        OP_REQ <= r;
        @(posedge MCLK);
        OP_VALID <= 1'b0;
        #1;
    endtask
    task automatic op(input dsa_pkg::dsa_op_t c, input logic s, input logic z,
        input logic [39:0] v);
        q = '0;
        q.code = c;
        q.acc_sel = s;
        q.zero_src = z;
        q.operand = v;
        send(q);
    endtask
    task automatic st(input dsa_pkg::dsa_op_t c, input logic [15:0] a, input logic [15:0] e);
        q = '0;
        q.code = c;
        q.xaddr = a;
        send(q);
        @(posedge MCLK);
        #1 peek_addr = a;
        #1 chk("store", 40'(peek_data), 40'(e));
    endtask
    task automatic wrap_up();
        $display("TB: checked %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (6) @(posedge MCLK);
        RESET <= 1'b0;
        rd_chk("core", dsa_pkg::REG_CORE_CTRL, 16'h0000);
        rd_chk("status", dsa_pkg::REG_STATUS, 16'h0000);
        rd_chk("unmapped", 4'hf, 16'h0000);
        $display("TB: reset test done");
        reg_wr(dsa_pkg::REG_CORE_CTRL, 16'h0090);
        reg_wr(dsa_pkg::REG_TRAP_CTRL, 16'h0002);
        op(dsa_pkg::OP_ADD, 1'b0, 1'b0, 40'h7fffffffff);
        chk("guard_trap", 40'(ARITH_TRAP), 40'h1);
        op(dsa_pkg::OP_ADD, 1'b0, 1'b0, 40'h0000000001);
        rd_chk("a_up", dsa_pkg::REG_ACC_A_UP, 16'h007f);
        rd_chk("a_lo", dsa_pkg::REG_ACC_A_LO, 16'hffff);
        op(dsa_pkg::OP_ADD, 1'b0, 1'b1, 40'h8000000000);
        op(dsa_pkg::OP_ADD, 1'b0, 1'b0, 40'hffffffffff);
        rd_chk("a_neg", dsa_pkg::REG_ACC_A_UP, 16'h0080);
        rd_chk("status", dsa_pkg::REG_STATUS, 16'h0035);
        chk("status_flags", 40'(STATUS_FLAGS), 40'h35);
        op(dsa_pkg::OP_ADD, 1'b0, 1'b1, 40'h0000000000);
        rd_chk("sticky", dsa_pkg::REG_STATUS, 16'h0024);
        reg_wr(dsa_pkg::REG_STATUS, 16'h0000);
        rd_chk("cleared", dsa_pkg::REG_STATUS, 16'h0000);
        $display("TB: clamp 40 test done");
        reg_wr(dsa_pkg::REG_CORE_CTRL, 16'h0040);
        op(dsa_pkg::OP_ADD, 1'b1, 1'b0, 40'h0100000000);
        rd_chk("b_hi", dsa_pkg::REG_ACC_B_HI, 16'h7fff);
        rd_chk("b_up", dsa_pkg::REG_ACC_B_UP, 16'h0000);
        rd_chk("status32", dsa_pkg::REG_STATUS, 16'h0028);
        $display("TB: clamp 32 test done");
        reg_wr(dsa_pkg::REG_CORE_CTRL, 16'h0000);
        reg_wr(dsa_pkg::REG_TRAP_CTRL, 16'h0001);
        op(dsa_pkg::OP_ADD, 1'b0, 1'b1, 40'h7fffffffff);
        chk("no_trap", 40'(ARITH_TRAP), 40'h0);
        op(dsa_pkg::OP_ADD, 1'b0, 1'b0, 40'h0000000001);
        chk("loss_trap", 40'(ARITH_TRAP), 40'h1);
        rd_chk("wrap", dsa_pkg::REG_ACC_A_UP, 16'h0080);
        rd_chk("limit", 4'(dsa_pkg::REG_STATUS), 16'h003d);
        $display("TB: wrap test done");
        op(dsa_pkg::OP_ADD, 1'b0, 1'b1, 40'h0012348000);
        st(dsa_pkg::OP_STORE, 16'h0100, 16'h1234);
        st(dsa_pkg::OP_STORE_RND, 16'h0102, 16'h1235);
        reg_wr(dsa_pkg::REG_CORE_CTRL, 16'h0002);
        st(dsa_pkg::OP_STORE_RND, 16'h0104, 16'h1234);
        op(dsa_pkg::OP_ADD, 1'b0, 1'b1, 40'h0012358000);
        st(dsa_pkg::OP_STORE_RND, 16'h0106, 16'h1236);
        reg_wr(dsa_pkg::REG_CORE_CTRL, 16'h0020);
        op(dsa_pkg::OP_ADD, 1'b0, 1'b1, 40'h0123450000);
        st(dsa_pkg::OP_STORE, 16'h0108, 16'h7fff);
        rd_chk("src_kept", dsa_pkg::REG_ACC_A_HI, 16'h2345);
        op(dsa_pkg::OP_ADD, 1'b0, 1'b1, 40'hff00000000);
        st(dsa_pkg::OP_STORE, 16'h010a, 16'h8000);
        reg_wr(dsa_pkg::REG_CORE_CTRL, 16'h0000);
        op(dsa_pkg::OP_ADD, 1'b0, 1'b1, 40'h0123450000);
        st(dsa_pkg::OP_STORE, 16'h010c, 16'h2345);
        $display("TB: round and store test done");
        reg_wr(dsa_pkg::REG_WB_PTR, 16'h0200);
        q = '0;
        q.code = dsa_pkg::OP_MAC;
        q.wb_en = 1'b1;
        q.wb_indirect = 1'b1;
        send(q);
        @(posedge MCLK);
        #1 peek_addr = 16'h0200;
        #1 chk("wb_data", 40'(peek_data), 40'h8000);
        rd_chk("wb_ptr", dsa_pkg::REG_WB_PTR, 16'h0202);
        q.wb_indirect = 1'b0;
        send(q);
        rd_chk("wb_direct", dsa_pkg::REG_WB_PTR, 16'h8000);
        cnt = wr_count;
        q.code = dsa_pkg::OP_MPY;
        q.wb_indirect = 1'b1;
        send(q);
        @(posedge MCLK);
        #1 chk("mpy_no_wb", 40'(wr_count), 40'(cnt));
        $display("TB: write-back test done");
        q = '0;
        q.code = dsa_pkg::OP_SHIFT_GP;
        q.shift_from_x = 1'b1;
        q.xdata = 16'h8421;
        for (int i = 0; i < 8; i++) begin
            q.shift_amt = amts[i];
            q.shift_arith = ariths[i];
            send(q);
            chk("gp_valid", 40'(GP_VALID), 40'h1);
            chk("gp_result", 40'(GP_RESULT), 40'(gp_exp[i]));
        end
        op(dsa_pkg::OP_ADD, 1'b0, 1'b1, 40'h0012348000);
        q = '0;
        q.code = dsa_pkg::OP_SHIFT_ACC;
        q.shift_amt = 6'sd8;
        q.shift_arith = 1'b1;
        send(q);
        chk("acc_shift", SHIFT_RESULT, 40'h0000123480);
        $display("TB: shift test done");
        wrap_up();
    end
endmodule
